// >>> verilog/ssw_pkg.sv
// Purpose: shared constants and types for the supply supervisor watchdog
// Assumes: clk at 200 MHz; comparator results arrive synchronous to clk
// Notes: times are kept in their printed unit, cycle counts derive from them
package ssw_pkg;
    localparam int unsigned CLK_MHZ = 200;
    // reset hold options, in microseconds (1.4 ms, 28 ms, 200 ms, 1600 ms)
    localparam int unsigned HOLD_US_OPT0 = 1400;
    localparam int unsigned HOLD_US_OPT1 = 28000;
    localparam int unsigned HOLD_US_OPT2 = 200000;
    localparam int unsigned HOLD_US_OPT3 = 1600000;
    // default watchdog window in microseconds; factory choice, value is plain
    localparam int unsigned WDOG_US_DEFAULT = 1600000;
    localparam int unsigned CNT_W = 32;
    localparam logic [1:0] HOLD_OPT_DEFAULT = 2'h2;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;

    // comparator results seen by the block
    typedef struct packed {
        logic supply_low;     // supply below reset threshold
        logic supply_lowline; // supply below low_line_level
        logic manual_low;     // manual_reset_in_n below manual_reset_level
    } ssw_cmp_t;

    typedef enum logic [1:0] {
        SSW_RUN,
        SSW_FAULT,
        SSW_HOLD
    } ssw_state_t;

    typedef struct packed {
        logic reset_n;
        logic reset_hi;
        logic low_line_warn_n;
    } ssw_out_t;
endpackage

// >>> verilog/ssw_timer.sv
// Purpose: restartable down counter that flags expiry of a fixed period
// Assumes: period of at least one cycle
// Notes: expired is a one-cycle pulse when the count reaches its end
`timescale 1ns/100ps
module ssw_timer #(
    parameter logic [ssw_pkg::CNT_W-1:0] PERIOD = 32'h00000010
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic restart,
    input wire logic run,
    output logic expired
);
    typedef struct packed {
        logic [ssw_pkg::CNT_W-1:0] left;
        logic expired;
    } ssw_tmr_st_t;

    ssw_tmr_st_t st_reg;
    ssw_tmr_st_t st_next;

    // restart takes priority so a fresh period always starts whole
    always_comb begin
        st_next = st_reg;
        st_next.expired = 1'b0;
        if (restart || !run) begin
            st_next.left = PERIOD;
        end else if (st_reg.left == ssw_pkg::CNT_ONE) begin
            st_next.expired = 1'b1;
            st_next.left = PERIOD;
        end else begin
            st_next.left = st_reg.left - ssw_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '{left: PERIOD, expired: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.expired;
endmodule

// >>> verilog/ssw_supervisor.sv
// Purpose: reset timing and watchdog logic of a supply supervisor
// Assumes: comparator inputs are synchronous to clk; options fixed at build
// Notes: reset is held low through faults and for one hold time afterwards
`timescale 1ns/100ps
module ssw_supervisor #(
    parameter logic [1:0] HOLD_OPT = ssw_pkg::HOLD_OPT_DEFAULT,
    parameter int unsigned WDOG_US = ssw_pkg::WDOG_US_DEFAULT,
    // cycle counts exceed 4096, so a simulation may override them directly
    parameter int unsigned HOLD_CYCLES_OVR = 0,
    parameter int unsigned WDOG_CYCLES_OVR = 0
) (
    input wire logic clk,
    input wire logic srst,
    input wire ssw_pkg::ssw_cmp_t cmp,
    input wire logic watchdog_edge_in,
    output ssw_pkg::ssw_out_t outs
);
    // fixed hold option chosen at build time
    localparam int unsigned HOLD_US = (HOLD_OPT == 2'h0) ? ssw_pkg::HOLD_US_OPT0 :
                                      (HOLD_OPT == 2'h1) ? ssw_pkg::HOLD_US_OPT1 :
                                      (HOLD_OPT == 2'h2) ? ssw_pkg::HOLD_US_OPT2 :
                                      ssw_pkg::HOLD_US_OPT3;
    localparam int unsigned HOLD_CYC = (HOLD_CYCLES_OVR != 0) ? HOLD_CYCLES_OVR :
                                       HOLD_US * ssw_pkg::CLK_MHZ;
    localparam int unsigned WDOG_CYC = (WDOG_CYCLES_OVR != 0) ? WDOG_CYCLES_OVR :
                                       WDOG_US * ssw_pkg::CLK_MHZ;
    localparam logic [ssw_pkg::CNT_W-1:0] HOLD_P = HOLD_CYC[ssw_pkg::CNT_W-1:0];
    localparam logic [ssw_pkg::CNT_W-1:0] WDOG_P = WDOG_CYC[ssw_pkg::CNT_W-1:0];

    typedef struct packed {
        ssw_pkg::ssw_state_t state;
        logic wd_last;
        logic [ssw_pkg::CNT_W-1:0] hold_left;
        ssw_pkg::ssw_out_t outs;
    } ssw_st_t;

    ssw_st_t st_reg;
    ssw_st_t st_next;
    logic fault;
    logic wd_edge;
    logic wdog_restart;
    logic wdog_run;
    logic wdog_expired;

    assign fault = cmp.supply_low | cmp.manual_low;
    assign wd_edge = watchdog_edge_in ^ st_reg.wd_last;
    // restart on any edge; the timer is held full while reset is active
    assign wdog_restart = wd_edge;
    // counting only in run means a whole window starts when a reset ends
    assign wdog_run = (st_reg.state == ssw_pkg::SSW_RUN);

    // watchdog window counter; expiry requests a reset pulse
    ssw_timer #(
        .PERIOD(WDOG_P)
    ) u_wdog (
        .clk(clk),
        .srst(srst),
        .restart(wdog_restart),
        .run(wdog_run),
        .expired(wdog_expired)
    );

    // reset sequencing: fault holds, then one hold time before release
    always_comb begin
        st_next = st_reg;
        st_next.wd_last = watchdog_edge_in;
        case (st_reg.state)
            ssw_pkg::SSW_RUN: begin
                if (fault) begin
                    st_next.state = ssw_pkg::SSW_FAULT;
                end else if (wdog_expired) begin
                    st_next.state = ssw_pkg::SSW_HOLD;
                    st_next.hold_left = HOLD_P;
                end
            end
            ssw_pkg::SSW_FAULT: begin
                if (!fault) begin
                    st_next.state = ssw_pkg::SSW_HOLD;
                    st_next.hold_left = HOLD_P;
                end
            end
            ssw_pkg::SSW_HOLD: begin
                if (fault) begin
                    st_next.state = ssw_pkg::SSW_FAULT;
                end else if (st_reg.hold_left == ssw_pkg::CNT_ONE) begin
                    st_next.state = ssw_pkg::SSW_RUN;
                    st_next.hold_left = ssw_pkg::CNT_ZERO;
                end else begin
                    st_next.hold_left = st_reg.hold_left - ssw_pkg::CNT_ONE;
                end
            end
            default: begin
                st_next.state = ssw_pkg::SSW_FAULT;
            end
        endcase
        // reset_n and reset_hi registered from the next state so they track it exactly; the warning from supply_lowline
        st_next.outs.reset_n = (st_next.state == ssw_pkg::SSW_RUN);
        st_next.outs.reset_hi = ~st_next.outs.reset_n;
        st_next.outs.low_line_warn_n = ~cmp.supply_lowline;
    end

    // srst starts a full power-up reset: fault state, reset asserted
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '{state: ssw_pkg::SSW_FAULT, wd_last: 1'b0,
                        hold_left: ssw_pkg::CNT_ZERO,
                        outs: '{reset_n: 1'b0, reset_hi: 1'b1, low_line_warn_n: 1'b0}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign outs = st_reg.outs;
endmodule

// >>> testbench/ssw_properties.sv
// Purpose: port checks for ssw_supervisor
// Assumes: hold and window overrides nonzero
// Notes: counts allow two cycles of slack for latency, three for the watchdog window check
`timescale 1ns/100ps
module ssw_properties #(
    parameter int unsigned HOLD_CYCLES_OVR = 0,
    parameter int unsigned WDOG_CYCLES_OVR = 0
) (
    input wire logic clk,
    input wire logic srst,
    input wire ssw_pkg::ssw_cmp_t cmp,
    input wire logic watchdog_edge_in,
    input wire ssw_pkg::ssw_out_t outs
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic flt;
    logic wd_reg;
    int quiet_reg;
    int idle_reg;
    assign flt = cmp.supply_low | cmp.manual_low;
    // quiet: cycles held with no fault; idle: cycles since the watchdog count restarted
    always_ff @(posedge clk) begin
        wd_reg <= watchdog_edge_in;
        quiet_reg <= (srst || outs.reset_n || flt) ? 0 : quiet_reg + 1;
        idle_reg <= (srst || !outs.reset_n || wd_reg != watchdog_edge_in) ? 0 : idle_reg + 1;
    end
    sequence s_low8;
        !outs.reset_n [*8];
    endsequence
    property p_inverse; outs.reset_hi == !outs.reset_n; endproperty
    property p_fault; flt |=> !outs.reset_n; endproperty
    property p_warn; !$past(srst) |-> outs.low_line_warn_n == !$past(cmp.supply_lowline);
    endproperty
    property p_clear; $fell(flt) |-> s_low8; endproperty
    property p_pulse; $fell(outs.reset_n) |=> s_low8; endproperty
    property p_release;
        $rose(outs.reset_n) |-> quiet_reg inside {[HOLD_CYCLES_OVR-2:HOLD_CYCLES_OVR+2]};
    endproperty
    property p_window; idle_reg <= WDOG_CYCLES_OVR + 3; endproperty
    property p_restart; $fell(outs.reset_n) && !$past(flt) |-> idle_reg + 2 >= WDOG_CYCLES_OVR;
    endproperty
    a_inverse: assert property (p_inverse) else $error("reset_hi not inverse");
    a_fault: assert property (p_fault) else $error("fault without reset");
    a_warn: assert property (p_warn) else $error("warning output wrong");
    a_clear: assert property (p_clear) else $error("reset left early");
    a_pulse: assert property (p_pulse) else $error("reset pulse short");
    a_release: assert property (p_release) else $error("hold length wrong");
    a_window: assert property (p_window) else $error("watchdog missed");
    a_restart: assert property (p_restart) else $error("watchdog early");
endmodule
bind ssw_supervisor ssw_properties #(.HOLD_CYCLES_OVR(HOLD_CYCLES_OVR),
    .WDOG_CYCLES_OVR(WDOG_CYCLES_OVR)) ssw_properties_inst (.clk(clk), .srst(srst),
    .cmp(cmp), .watchdog_edge_in(watchdog_edge_in), .outs(outs));

// >>> testbench/ssw_host.sv
// Purpose: host processor model strobing the watchdog line
// Assumes: active comes from the bench
// Notes: an idle host leaves the line still so the watchdog must fire
`timescale 1ns/100ps
module ssw_host #(
    parameter int unsigned PERIOD = 10
) (
    input wire logic clk,
    input wire logic active,
    output logic wd_line
);
    int cnt_reg = 0;
    initial wd_line = 1'h0;
    // toggle well inside the window, just after the edge
    always @(posedge clk) begin
        cnt_reg <= (cnt_reg + 1) % PERIOD;
        if (active && cnt_reg == 0) begin
            wd_line <= #1 ~wd_line;
        end
    end
endmodule

// >>> testbench/ssw_supervisor_bench.sv
// Purpose: self-checking bench for ssw_supervisor
// Assumes: hold 20 and window 50 cycles by override
// Notes: a host model strobes the watchdog line
`timescale 1ns/100ps
module ssw_supervisor_bench;
    localparam int HOLD = 20;
    localparam int WDOG = 50;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic active = 1'h0;
    logic wd_line;
    ssw_pkg::ssw_cmp_t cmp = 3'h0;
    ssw_pkg::ssw_out_t outs;
    int err_total = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    ssw_supervisor #(.HOLD_CYCLES_OVR(HOLD), .WDOG_CYCLES_OVR(WDOG)) ssw_supervisor_inst (
        .clk(clk), .srst(srst), .cmp(cmp), .watchdog_edge_in(wd_line), .outs(outs));
    ssw_host #(.PERIOD(10)) ssw_host_inst (.clk(clk), .active(active), .wd_line(wd_line));
    task automatic chk(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic near(input string what, input int exp, input int got);
        check_count++;
        if (got < exp - 2 || got > exp + 2) begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // counts edges until reset_n reaches lvl; bounded so a stuck output cannot hang
    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (outs.reset_n !== lvl && n < 500) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // fault, release, then a fault again in mid-hold which restarts the hold
    task automatic t_fault(input logic [2:0] code);
        int n;
        cmp = code;
        repeat (5) @(posedge clk);
        #1 chk("reset_n in fault", 1'h0, outs.reset_n);
        chk("reset_hi in fault", 1'h1, outs.reset_hi);
        cmp = 3'h0;
        repeat (5) @(posedge clk);
        #1 cmp = code;
        @(posedge clk);
        #1 cmp = 3'h0;
        wait_lvl(1'h1, n);
        near("hold after fault", HOLD + 1, n);
        chk("reset_hi released", 1'h0, outs.reset_hi);
        $display("fault test done");
    endtask
    task automatic t_lowline();
        cmp = 3'h2;
        repeat (2) @(posedge clk);
        #1 chk("warning low", 1'h0, outs.low_line_warn_n);
        chk("reset_n before threshold", 1'h1, outs.reset_n);
        cmp = 3'h0;
        repeat (2) @(posedge clk);
        #1 chk("warning high", 1'h1, outs.low_line_warn_n);
        $display("low line test done");
    endtask
    // steady host keeps reset away; a silent host gets pulses that restart the count
    task automatic t_wdog();
        int n;
        active = 1'h1;
        repeat (3 * WDOG) @(posedge clk);
        #1 chk("reset_n while strobed", 1'h1, outs.reset_n);
        @(wd_line);
        active = 1'h0;
        for (int i = 0; i < 2; i++) begin
            wait_lvl(1'h0, n);
            near("watchdog expiry", WDOG + 1, n);
            wait_lvl(1'h1, n);
            near("watchdog pulse", HOLD, n);
        end
        $display("watchdog test done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #25000 err_total++;
        summarize();
    end
    initial begin
        int n;
        repeat (20) @(posedge clk);
        #1 srst = 1'h0;
        wait_lvl(1'h1, n);
        near("hold after reset", HOLD, n);
        t_fault(3'h6);
        t_fault(3'h1);
        t_lowline();
        t_wdog();
        summarize();
    end
endmodule
